//--- rtl/crt_timing_register_set.sv
`timescale 1ns/1ps
module crt_timing_register_set (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        char_en,
  input  wire logic [7:0]  h_total,
  input  wire logic [7:0]  hblank_start,
  input  wire logic [4:0]  hblank_end_lo,
  input  wire logic [1:0]  io_sel,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             hblank,
  output logic             hretrace,
  output logic             vretrace,
  output logic             vdisp_active,
  output logic             cursor,
  output logic             underline,
  output logic      [15:0] mem_addr,
  output logic      [4:0]  row_scan,
  output logic             refresh_strobe,
  output logic      [1:0]  line_cmp_hi,
  output logic      [1:0]  vblank_start_hi,
  output logic             irq
);

  typedef logic [7:0] byte_t;

  // Picks a tap of a skew line
  function automatic logic skew_pick(
    input logic [crt_timing_pkg::SKEW_TAPS-1:0] taps,
    input logic [1:0] sel
  );
    skew_pick = taps[sel];
  endfunction : skew_pick

  byte_t      regs_q [crt_timing_pkg::REG_FIRST:crt_timing_pkg::REG_LAST];
  logic [4:0] index_q;
  logic [7:0] hcount_q;
  logic [9:0] vcount_q;
  logic       hblank_q;
  logic       hret_raw_q;
  logic       vret_q;
  logic       dbl_phase_q;
  logic [4:0] row_q;
  logic [15:0] row_addr_q;
  logic [15:0] ma_q;
  logic [1:0] div_q;
  logic [2:0] refresh_left_q;
  logic       irq_flag_q;
  logic [crt_timing_pkg::SKEW_TAPS-1:0] hret_line_q;
  logic [crt_timing_pkg::SKEW_TAPS-1:0] cur_line_q;

  // Named views of the registers
  wire byte_t hrs = regs_q[crt_timing_pkg::IDX_HRETRACE_START];
  wire byte_t hre = regs_q[crt_timing_pkg::IDX_HRETRACE_END];
  wire byte_t vtl = regs_q[crt_timing_pkg::IDX_VERTICAL_LINE_TOTAL];
  wire byte_t ovf = regs_q[crt_timing_pkg::IDX_OVERFLOW_HIGH_BITS];
  wire byte_t rsp = regs_q[crt_timing_pkg::IDX_ROW_SCAN_PRESET];
  wire byte_t msl = regs_q[crt_timing_pkg::IDX_ROW_HEIGHT_LIMIT];
  wire byte_t mrb = regs_q[crt_timing_pkg::IDX_MARKER_ROW_BEGIN];
  wire byte_t mrf = regs_q[crt_timing_pkg::IDX_MARKER_ROW_FINISH];
  wire byte_t dbh = regs_q[crt_timing_pkg::IDX_DISPLAY_BASE_HI];
  wire byte_t dbl = regs_q[crt_timing_pkg::IDX_DISPLAY_BASE_LO];
  wire byte_t mph = regs_q[crt_timing_pkg::IDX_MARKER_POS_HI];
  wire byte_t mpl = regs_q[crt_timing_pkg::IDX_MARKER_POS_LO];
  wire byte_t vrs = regs_q[crt_timing_pkg::IDX_VRETRACE_START];
  wire byte_t vre = regs_q[crt_timing_pkg::IDX_VRETRACE_END_CTRL];
  wire byte_t vde = regs_q[crt_timing_pkg::IDX_VACTIVE_END];
  wire byte_t pit = regs_q[crt_timing_pkg::IDX_ROW_PITCH];
  wire byte_t ulr = regs_q[crt_timing_pkg::IDX_UNDERSCORE_ROW];

  // Host port decode
  wire        wr_index  = io_wr && (io_sel == crt_timing_pkg::PORT_INDEX);
  wire        wr_data   = io_wr && (io_sel == crt_timing_pkg::PORT_DATA);
  wire        protect   = vre[crt_timing_pkg::VRE_PROTECT];
  wire        idx_prot  = index_q <= crt_timing_pkg::IDX_PROTECT_LAST;
  wire        idx_ovf   = index_q == crt_timing_pkg::IDX_OVERFLOW_HIGH_BITS;
  wire        in_range  =
    (index_q >= 5'(crt_timing_pkg::REG_FIRST)) &&
    (index_q <= 5'(crt_timing_pkg::REG_LAST));

  // Assembled six-bit, ten-bit and sixteen-bit values
  wire [9:0]  vtotal     = {ovf[crt_timing_pkg::OVF_VT_B9],
                            ovf[crt_timing_pkg::OVF_VT_B8], vtl};
  wire [9:0]  vret_start = {ovf[crt_timing_pkg::OVF_VRS_B9],
                            ovf[crt_timing_pkg::OVF_VRS_B8], vrs};
  wire [9:0]  vdisp_end  = {ovf[crt_timing_pkg::OVF_VDE_B9],
                            ovf[crt_timing_pkg::OVF_VDE_B8], vde};
  wire [15:0] base_addr  = {dbh, dbl};
  wire [15:0] cur_loc    = {mph, mpl};
  wire [5:0]  hblank_end = {hre[crt_timing_pkg::HRE_HBLANK_B5],
                            hblank_end_lo};

  // Horizontal compares
  wire h_wrap  = {1'b0, hcount_q} ==
                 ({1'b0, h_total} + crt_timing_pkg::HTOTAL_ADJ);
  wire hb_on   = hcount_q == hblank_start;
  wire hb_off  = hcount_q[5:0] == hblank_end;
  wire hr_on   = hcount_q == hrs;
  wire hr_off  = hcount_q[4:0] == hre[4:0];
  wire line_ev = char_en && hr_on && !hret_raw_q;

  // Vertical compares
  wire v_wrap  = vcount_q == (vtotal + crt_timing_pkg::VTOTAL_ADJ);
  wire vr_on   = vcount_q == vret_start;
  wire vr_off  = vcount_q[3:0] == vre[3:0];
  wire vr_rise = line_ev && vr_on && !vret_q;
  wire vr_fall = line_ev && vret_q && vr_off;

  // Row scan stepping
  wire row_step = line_ev && (!msl[crt_timing_pkg::MSL_DOUBLE] ||
                              dbl_phase_q);
  wire row_max  = row_q == msl[4:0];
  wire [15:0] pitch_step = ulr[crt_timing_pkg::UL_DWORD] ?
                           {6'h00, pit, 2'h0} : {7'h00, pit, 1'b0};
  wire ma_tick  = char_en && (!ulr[crt_timing_pkg::UL_DIV4] ||
                              div_q == crt_timing_pkg::DIV4_LAST);

  // Cursor and underline
  wire cur_ok   = !mrb[crt_timing_pkg::CUR_OFF] && (mrb[4:0] <= mrf[4:0]);
  wire cur_rows = (row_q >= mrb[4:0]) && (row_q <= mrf[4:0]);
  wire cur_now  = cur_ok && cur_rows && (ma_q == cur_loc);
  wire ul_now   = row_q == (ulr[4:0] + crt_timing_pkg::UNDERLINE_ADJ);

  wire [2:0] refresh_total = vre[crt_timing_pkg::VRE_FIVE_REFR] ?
    crt_timing_pkg::REFRESH_MANY : crt_timing_pkg::REFRESH_FEW;

  wire byte_t read_val =
    (io_sel == crt_timing_pkg::PORT_INDEX)   ? {3'h0, index_q} :
    (io_sel == crt_timing_pkg::PORT_STATUS0) ?
      byte_t'({irq_flag_q, 7'h00}) :
    (io_sel == crt_timing_pkg::PORT_DATA && in_range) ? regs_q[index_q] :
    crt_timing_pkg::REG_RESET;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      index_q <= 5'h00;
    else if (wr_index)
      index_q <= io_wdata[4:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      io_rdata <= crt_timing_pkg::REG_RESET;
    else if (io_rd)
      io_rdata <= read_val;
  end

  // One write path per register
  genvar gi;
  generate
    for (gi = crt_timing_pkg::REG_FIRST; gi <= crt_timing_pkg::REG_LAST;
         gi = gi + 1)
    begin : g_reg
      wire hit = wr_data && (index_q == 5'(gi));
      wire locked = protect && idx_prot;
      wire [7:0] mask = !locked ? 8'hFF :
                        idx_ovf ? 8'h10 : 8'h00;
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          regs_q[gi] <= crt_timing_pkg::REG_RESET;
        else if (hit)
          regs_q[gi] <= (regs_q[gi] & ~mask) | (io_wdata & mask);
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hcount_q <= 8'h00;
    else if (char_en)
      hcount_q <= h_wrap ? 8'h00 : hcount_q + 8'h01;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hblank_q <= 1'b0;
    else if (char_en && hb_on)
      hblank_q <= 1'b1;
    else if (char_en && hb_off)
      hblank_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hret_raw_q <= 1'b0;
    else if (char_en && hr_on)
      hret_raw_q <= 1'b1;
    else if (char_en && hr_off)
      hret_raw_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hret_line_q <= '0;
      cur_line_q  <= '0;
    end
    else if (char_en)
    begin
      hret_line_q <= {hret_line_q[crt_timing_pkg::SKEW_TAPS-2:0],
                      hret_raw_q};
      cur_line_q  <= {cur_line_q[crt_timing_pkg::SKEW_TAPS-2:0], cur_now};
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vcount_q <= 10'h000;
      vret_q   <= 1'b0;
    end
    else if (line_ev)
    begin
      vcount_q <= v_wrap ? 10'h000 : vcount_q + 10'h001;
      if (vr_on && !vret_q)
        vret_q <= 1'b1;
      else if (vr_off)
        vret_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dbl_phase_q <= 1'b0;
      row_q       <= 5'h00;
      row_addr_q  <= 16'h0000;
    end
    else if (vr_fall)
    begin
      dbl_phase_q <= 1'b0;
      row_q       <= rsp[4:0];
      row_addr_q  <= base_addr;
    end
    else if (line_ev)
    begin
      dbl_phase_q <= !dbl_phase_q;
      if (row_step && row_max)
      begin
        row_q      <= 5'h00;
        row_addr_q <= row_addr_q + pitch_step;
      end
      else if (row_step)
        row_q <= row_q + 5'h01;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_q <= 2'h0;
      ma_q  <= 16'h0000;
    end
    else if (char_en && h_wrap)
    begin
      div_q <= 2'h0;
      ma_q  <= row_addr_q;
    end
    else if (char_en)
    begin
      div_q <= div_q + 2'h1;
      if (ma_tick)
        ma_q <= ma_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      refresh_left_q <= 3'h0;
      refresh_strobe <= 1'b0;
    end
    else if (char_en && hb_on)
    begin
      refresh_left_q <= refresh_total;
      refresh_strobe <= 1'b0;
    end
    else if (char_en && refresh_left_q != 3'h0)
    begin
      refresh_left_q <= refresh_left_q - 3'h1;
      refresh_strobe <= 1'b1;
    end
    else
      refresh_strobe <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_flag_q <= 1'b0;
    else if (!vre[crt_timing_pkg::VRE_IRQ_CLR_N])
      irq_flag_q <= 1'b0;
    else if (vr_rise)
      irq_flag_q <= 1'b1;
  end

  // Registered outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hblank          <= 1'b0;
      hretrace        <= 1'b0;
      vretrace        <= 1'b0;
      vdisp_active    <= 1'b0;
      cursor          <= 1'b0;
      underline       <= 1'b0;
      mem_addr        <= 16'h0000;
      row_scan        <= 5'h00;
      line_cmp_hi     <= 2'h0;
      vblank_start_hi <= 2'h0;
      irq             <= 1'b0;
    end
    else
    begin
      hblank       <= hblank_q;
      hretrace     <= skew_pick({hret_line_q[2:0], hret_raw_q},
                                hre[crt_timing_pkg::SKEW_HI:
                                    crt_timing_pkg::SKEW_LO]);
      vretrace     <= vret_q;
      vdisp_active <= vcount_q <= vdisp_end;
      cursor       <= skew_pick({cur_line_q[2:0], cur_now},
                                mrf[crt_timing_pkg::SKEW_HI:
                                    crt_timing_pkg::SKEW_LO]);
      underline    <= ul_now;
      mem_addr     <= ma_q;
      row_scan     <= row_q;
      line_cmp_hi     <= {msl[crt_timing_pkg::MSL_LC_B9],
                          ovf[crt_timing_pkg::OVF_LC_B8]};
      vblank_start_hi <= {msl[crt_timing_pkg::MSL_VBS_B9],
                          ovf[crt_timing_pkg::OVF_VBS_B8]};
      irq <= irq_flag_q && !vre[crt_timing_pkg::VRE_IRQ_OFF];
    end
  end

endmodule : crt_timing_register_set

//--- pkg/crt_timing_pkg.sv
// Overview of operation
// - Horizontal blank ends on six-bit match
// - Horizontal retrace starts at programmed position
// - Horizontal retrace ends on five-bit match
// - Horizontal retrace skewed zero to three
// - Vertical total ten bits, lines minus two
// - Overflow register carries high timing bits
// - Row counter preset, increments, clears at max
// - Double scan halves row counter clock
// - Maximum scan line is rows minus one
// - Cursor off by bit or start>end
// - Cursor end row and cursor skew
// - Start address loaded after vertical retrace
// - Cursor location from two bytes
// - Vertical retrace starts at ten-bit line
// - Write protect registers zero to seven, except overflow bit four
// - Three or five refresh cycles per line
// - Vertical retrace interrupt, status bit seven
// - Interrupt cleared while clear bit zero
// - Vertical retrace ends on four-bit match
// - Row address advances by 2x/4x offset
// - Doubleword mode and divide-by-four clocking
// - Underline on programmed row plus one
// - Character counter drives horizontal timing
package crt_timing_pkg;

  // Host port selects
  localparam logic [1:0] PORT_INDEX   = 2'h0;
  localparam logic [1:0] PORT_DATA    = 2'h1;
  localparam logic [1:0] PORT_STATUS0 = 2'h2;

  // Register indices held by this block
  localparam logic [4:0] IDX_HRETRACE_START      = 5'h04;
  localparam logic [4:0] IDX_HRETRACE_END        = 5'h05;
  localparam logic [4:0] IDX_VERTICAL_LINE_TOTAL = 5'h06;
  localparam logic [4:0] IDX_OVERFLOW_HIGH_BITS  = 5'h07;
  localparam logic [4:0] IDX_ROW_SCAN_PRESET     = 5'h08;
  localparam logic [4:0] IDX_ROW_HEIGHT_LIMIT    = 5'h09;
  localparam logic [4:0] IDX_MARKER_ROW_BEGIN    = 5'h0A;
  localparam logic [4:0] IDX_MARKER_ROW_FINISH   = 5'h0B;
  localparam logic [4:0] IDX_DISPLAY_BASE_HI     = 5'h0C;
  localparam logic [4:0] IDX_DISPLAY_BASE_LO     = 5'h0D;
  localparam logic [4:0] IDX_MARKER_POS_HI       = 5'h0E;
  localparam logic [4:0] IDX_MARKER_POS_LO       = 5'h0F;
  localparam logic [4:0] IDX_VRETRACE_START      = 5'h10;
  localparam logic [4:0] IDX_VRETRACE_END_CTRL   = 5'h11;
  localparam logic [4:0] IDX_VACTIVE_END         = 5'h12;
  localparam logic [4:0] IDX_ROW_PITCH           = 5'h13;
  localparam logic [4:0] IDX_UNDERSCORE_ROW      = 5'h14;

  localparam int REG_FIRST = 4;
  localparam int REG_LAST  = 20;
  // Highest index covered by write protection
  localparam logic [4:0] IDX_PROTECT_LAST = 5'h07;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions
  localparam int HRE_HBLANK_B5   = 7;
  localparam int SKEW_HI         = 6;
  localparam int SKEW_LO         = 5;
  localparam int OVF_VT_B8       = 0;
  localparam int OVF_VDE_B8      = 1;
  localparam int OVF_VRS_B8      = 2;
  localparam int OVF_VBS_B8      = 3;
  localparam int OVF_LC_B8       = 4;
  localparam int OVF_VT_B9       = 5;
  localparam int OVF_VDE_B9      = 6;
  localparam int OVF_VRS_B9      = 7;
  localparam int MSL_DOUBLE      = 7;
  localparam int MSL_LC_B9       = 6;
  localparam int MSL_VBS_B9      = 5;
  localparam int CUR_OFF         = 5;
  localparam int VRE_PROTECT     = 7;
  localparam int VRE_FIVE_REFR   = 6;
  localparam int VRE_IRQ_OFF     = 5;
  localparam int VRE_IRQ_CLR_N   = 4;
  localparam int UL_DWORD        = 6;
  localparam int UL_DIV4         = 5;
  localparam int STATUS0_IRQ     = 7;

  // Timing figures
  localparam logic [8:0] HTOTAL_ADJ    = 9'h004;
  localparam logic [9:0] VTOTAL_ADJ    = 10'h001;
  localparam logic [4:0] UNDERLINE_ADJ = 5'h01;
  localparam logic [2:0] REFRESH_FEW   = 3'h3;
  localparam logic [2:0] REFRESH_MANY  = 3'h5;
  localparam logic [1:0] DIV4_LAST     = 2'h3;
  localparam int SKEW_TAPS = 4;

endpackage : crt_timing_pkg

//--- test/host_cpu_model.sv
`timescale 1ns/1ps
module host_cpu_model (
  input  wire logic       clk,
  input  wire logic [7:0] io_rdata,
  output logic            char_en,
  output logic      [1:0] io_sel,
  output logic            io_wr,
  output logic            io_rd,
  output logic      [7:0] io_wdata
);
  logic [1:0] div_q;

  initial
  begin
    div_q = 2'h0;
    char_en = 1'b0;
    io_sel = 2'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // One character every four clocks keeps lag checks sharp
  always @(negedge clk)
  begin
    div_q <= div_q + 2'h1;
    char_en <= (div_q == 2'h3);
  end

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    @(negedge clk);
    io_sel = crt_timing_pkg::PORT_INDEX;
    io_wdata = {3'h0, idx};
    io_wr = 1'b1;
    @(negedge clk);
    io_sel = crt_timing_pkg::PORT_DATA;
    io_wdata = d;
    @(negedge clk);
    io_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] sel, output logic [7:0] d);
    @(negedge clk);
    io_sel = sel;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask : rd

  task automatic rdi(input logic [4:0] idx, output logic [7:0] d);
    @(negedge clk);
    io_sel = crt_timing_pkg::PORT_INDEX;
    io_wdata = {3'h0, idx};
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    rd(crt_timing_pkg::PORT_DATA, d);
  endtask : rdi

  // keep other bits, clear then re-arm
  task automatic ack;
    logic [7:0] c;
    rdi(5'h11, c);
    wr(5'h11, c & 8'hEF);
    wr(5'h11, c | 8'h10);
  endtask : ack
endmodule : host_cpu_model

//--- test/crt_timing_sva.sv
`timescale 1ns/1ps
module crt_timing_sva (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        char_en,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_rdata,
  input wire logic        hblank,
  input wire logic        hretrace,
  input wire logic        vretrace,
  input wire logic [15:0] mem_addr,
  input wire logic [4:0]  row_scan,
  input wire logic        refresh_strobe,
  input wire logic [1:0]  line_cmp_hi,
  input wire logic        irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  rdata_hold_a: assert property (
    $changed(io_rdata) |-> $past(io_rd)) else $error("rdata moved");
  hblank_step_a: assert property (
    $changed(hblank) |-> $past(char_en, 2) || $past(char_en, 3))
    else $error("hblank off character");
  // A skew change written mid-retrace moves the output off a character
  hret_step_a: assert property (
    $changed(hretrace) |-> $past(char_en, 2) || $past(char_en, 3)
    || $past(io_wr, 2)) else $error("hretrace off character");
  vret_step_a: assert property (
    $changed(vretrace) |-> $past(char_en, 2) || $past(char_en, 3))
    else $error("vretrace off character");
  row_step_a: assert property (
    $changed(row_scan) |-> row_scan == 5'h00 || $fell(vretrace)
    || row_scan == $past(row_scan) + 5'h01) else $error("row jump");
  maddr_step_a: assert property (
    $changed(mem_addr) |-> $past(char_en, 2) || $past(char_en, 3))
    else $error("address off character");
  refresh_one_a: assert property (
    refresh_strobe |-> ($past(char_en) || $past(char_en, 2))
    ##1 !refresh_strobe) else $error("refresh strobe shape");
  irq_rise_a: assert property (
    $rose(irq) |-> vretrace || $past(vretrace) || $past(io_wr, 2))
    else $error("irq without retrace");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(io_wr, 2) || $past(io_wr, 3))
    else $error("irq dropped alone");
  high_bits_a: assert property (
    $changed(line_cmp_hi) |-> $past(io_wr) || $past(io_wr, 2))
    else $error("high bits moved alone");

  cover property ($rose(irq));
  cover property ($fell(vretrace));
  cover property (refresh_strobe);
endmodule : crt_timing_sva

bind crt_timing_register_set crt_timing_sva chk_i (
  .clk(clk), .rst(rst), .char_en(char_en), .io_wr(io_wr),
  .io_rd(io_rd), .io_rdata(io_rdata), .hblank(hblank),
  .hretrace(hretrace), .vretrace(vretrace), .mem_addr(mem_addr),
  .row_scan(row_scan), .refresh_strobe(refresh_strobe),
  .line_cmp_hi(line_cmp_hi), .irq(irq)
);

//--- test/test_crt_timing_register_set.sv
`timescale 1ns/1ps
module test_crt_timing_register_set;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        char_en;
  logic [1:0]  io_sel;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        hblank;
  logic        hretrace;
  logic        vretrace;
  logic        underline;
  logic        cursor;
  logic        vdisp_active;
  logic [15:0] mem_addr;
  logic [4:0]  row_scan;
  logic        refresh_strobe;
  logic [1:0]  line_cmp_hi;
  logic [1:0]  vblank_start_hi;
  logic        irq;
  logic [7:0]  v;
  int          fails = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          n;

  always #20 clk = ~clk;

  host_cpu_model host (.clk(clk), .io_rdata(io_rdata),
    .char_en(char_en), .io_sel(io_sel), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata));

  crt_timing_register_set uut (.clk(clk), .rst(rst),
    .char_en(char_en), .h_total(8'h20), .hblank_start(8'h10),
    .hblank_end_lo(5'h1C), .io_sel(io_sel), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .hblank(hblank), .hretrace(hretrace), .vretrace(vretrace),
    .vdisp_active(vdisp_active), .cursor(cursor), .underline(underline),
    .mem_addr(mem_addr), .row_scan(row_scan),
    .refresh_strobe(refresh_strobe), .line_cmp_hi(line_cmp_hi),
    .vblank_start_hi(vblank_start_hi), .irq(irq));

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait for a level, n counts clocks spent
  task automatic till(ref logic s, input logic lv, output int k);
    k = 0;
    while (s !== lv && k < 4000)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 4000)
    begin
      fails++;
      $display("[ERR] %0t got=%h exp=%h", $time, s, lv);
    end
  endtask : till

  // Line of 37 characters, frame of 18 lines, row height 4
  task automatic cfg(input logic [7:0] hre);
    host.wr(5'h11, 8'h1B);
    host.wr(5'h04, 8'h14);
    host.wr(5'h05, hre);
    host.wr(5'h06, 8'h10);
    host.wr(5'h07, 8'h00);
    host.wr(5'h08, 8'h02);
    host.wr(5'h09, 8'h03);
    host.wr(5'h10, 8'h08);
    host.wr(5'h14, 8'h02);
    repeat (160) @(negedge clk);
  endtask : cfg

  task automatic t_regs;
    for (int i = 4; i <= 20; i++)
    begin
      host.rdi(5'(i), v);
      chk({8'h00, v}, {8'h00, crt_timing_pkg::REG_RESET});
      host.wr(5'(i), 8'(i) ^ 8'h5A);
    end
    for (int i = 4; i <= 20; i++)
    begin
      host.rdi(5'(i), v);
      chk({8'h00, v}, {8'h00, 8'(i) ^ 8'h5A});
    end
    host.wr(5'h15, 8'hFF);
    host.rdi(5'h15, v);
    chk({8'h00, v}, 16'h0000);
    chk({14'h0, line_cmp_hi}, 16'h0003);
    chk({14'h0, vblank_start_hi}, 16'h0001);
  endtask : t_regs

  task automatic t_protect;
    host.wr(5'h11, 8'h80);
    host.wr(5'h04, 8'h33);
    host.rdi(5'h04, v);
    chk({8'h00, v}, 16'h005E);
    host.wr(5'h07, 8'h00);
    host.rdi(5'h07, v);
    chk({8'h00, v}, 16'h004D);
    host.wr(5'h08, 8'h1F);
    host.rdi(5'h08, v);
    chk({8'h00, v}, 16'h001F);
    host.wr(5'h11, 8'h00);
    host.wr(5'h04, 8'h33);
    host.rdi(5'h04, v);
    chk({8'h00, v}, 16'h0033);
  endtask : t_protect

  task automatic t_hor;
    int d0;
    for (int s = 0; s < 4; s++)
    begin
      cfg({1'b0, 2'(s), 5'h18});
      till(hretrace, 1'b0, n);
      till(hretrace, 1'b1, n);
      till(hretrace, 1'b0, n);
      chk(16'(n), 16'h0010);
      till(hretrace, 1'b1, n);
      till(hblank, 1'b0, n);
      if (s == 0)
        d0 = n;
      chk(16'(d0 - n), 16'(4 * s));
    end
    till(hblank, 1'b1, n);
    till(hblank, 1'b0, n);
    chk(16'(n), 16'h0030);
  endtask : t_hor

  task automatic t_vert;
    cfg(8'h18);
    till(vretrace, 1'b0, n);
    till(vretrace, 1'b1, n);
    till(vretrace, 1'b0, n);
    chk(16'(n), 16'h01BC);
    till(vretrace, 1'b1, n);
    chk(16'(n), 16'h08AC);
    repeat (4) @(negedge clk);
    chk({15'h0, irq}, 16'h0001);
    host.rd(crt_timing_pkg::PORT_STATUS0, v);
    chk({8'h00, v & 8'h80}, 16'h0080);
    host.ack();
    repeat (4) @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    host.rd(crt_timing_pkg::PORT_STATUS0, v);
    chk({8'h00, v & 8'h80}, 16'h0000);
    host.wr(5'h11, 8'h3B);
    till(vretrace, 1'b0, n);
    till(vretrace, 1'b1, n);
    repeat (4) @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    host.rd(crt_timing_pkg::PORT_STATUS0, v);
    chk({8'h00, v & 8'h80}, 16'h0080);
    host.ack();
    host.wr(5'h11, 8'h1B);
  endtask : t_vert

  task automatic t_row(input logic dbl);
    logic [4:0] r [6];
    host.wr(5'h09, {dbl, 7'h03});
    till(vretrace, 1'b1, n);
    till(vretrace, 1'b0, n);
    repeat (74) @(negedge clk);
    for (int k = 0; k < 6; k++)
    begin
      r[k] = row_scan;
      chk({15'h0, underline}, {15'h0, row_scan == 5'h03});
      repeat (148) @(negedge clk);
    end
    chk({11'h0, r[0]}, 16'h0002);
    for (int k = 0; k < 4; k++)
      chk({11'h0, r[k + 32'(dbl) + 1]}, {14'h0, 2'(r[k] + 5'h01)});
  endtask : t_row

  // Start 0x1234, pitch 5, rows 0 to 3, display ends on line 12
  task automatic t_addr(input logic [7:0] ul, input logic [7:0] cb,
                        input logic [15:0] adv, input logic cur_on);
    logic [15:0] e0;
    e0 = ul[5] ? 16'h1234 : 16'h1237;
    host.wr(5'h09, 8'h03);
    host.wr(5'h0A, cb);
    host.wr(5'h0B, 8'h03);
    host.wr(5'h0C, 8'h12);
    host.wr(5'h0D, 8'h34);
    host.wr(5'h0E, e0[15:8]);
    host.wr(5'h0F, e0[7:0]);
    host.wr(5'h12, 8'h0C);
    host.wr(5'h13, 8'h05);
    host.wr(5'h14, ul);
    till(vretrace, 1'b1, n);
    till(vretrace, 1'b0, n);
    // Fourth character of the first line after retrace
    repeat (78) @(negedge clk);
    chk(mem_addr, e0);
    chk({15'h0, cursor}, {15'h0, cur_on});
    chk({15'h0, vdisp_active}, 16'h0001);
    // Same character two lines on, first line of next row
    repeat (296) @(negedge clk);
    chk(mem_addr, e0 + adv);
    chk({15'h0, cursor}, 16'h0000);
    chk({15'h0, vdisp_active}, 16'h0000);
  endtask : t_addr

  task automatic t_refr;
    int c;
    for (int f = 0; f < 2; f++)
    begin
      host.wr(5'h11, {1'b0, 1'(f), 6'h1B});
      repeat (160) @(negedge clk);
      till(hblank, 1'b0, n);
      till(hblank, 1'b1, n);
      c = 0;
      repeat (148)
      begin
        @(negedge clk);
        c += 32'(refresh_strobe);
      end
      chk(16'(c), (f == 1) ? 16'h0005 : 16'h0003);
    end
  endtask : t_refr

  // Whole run needs about 21000 clocks
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails++;
      test_done();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_protect();
    t_hor();
    t_vert();
    t_row(1'b0);
    t_row(1'b1);
    t_addr(8'h02, 8'h00, 16'h000A, 1'b1);
    t_addr(8'h42, 8'h20, 16'h0014, 1'b0);
    t_addr(8'h62, 8'h00, 16'h0014, 1'b1);
    t_refr();
    test_done();
  end
endmodule : test_crt_timing_register_set
